// [rtl/uafe_pkg.sv]
package uafe_pkg;

  // ==========================================================================
  // register indices
  localparam logic [5:0] UAFE_ADDR_FILTER    = 6'h10;
  localparam logic [5:0] UAFE_ADDR_FILTER2   = 6'h11;
  localparam logic [5:0] UAFE_ADDR_LOGAMP    = 6'h12;
  localparam logic [5:0] UAFE_ADDR_MODE      = 6'h14;
  localparam logic [5:0] UAFE_ADDR_DRIVE     = 6'h16;
  localparam logic [5:0] UAFE_ADDR_ECHO      = 6'h17;
  localparam logic [5:0] UAFE_ADDR_ZC        = 6'h18;
  localparam logic [5:0] UAFE_ADDR_STATUS    = 6'h1C;
  localparam logic [5:0] UAFE_ADDR_IRQ_STAT  = 6'h20;
  localparam logic [5:0] UAFE_ADDR_IRQ_MASK  = 6'h21;

  // ==========================================================================
  // field positions
  localparam int UAFE_FLT_HPF_BIT   = 6;
  localparam int UAFE_LOG_FIRST_BIT = 7;
  localparam int UAFE_LOG_LAST_BIT  = 6;
  localparam int UAFE_MODE_SLEEP    = 1;
  localparam int UAFE_MODE_STANDBY  = 0;
  localparam int UAFE_DRV_DISABLE   = 7;
  localparam int UAFE_ZC_EN_BIT     = 7;
  localparam int UAFE_ZC_GATE_BIT   = 6;
  localparam int UAFE_ECHO_RANGE    = 3;

  // ==========================================================================
  // reset values
  localparam logic [7:0] UAFE_RST_ZERO = 8'h00;
  localparam logic [7:0] UAFE_RST_MODE = 8'h02;

  // ==========================================================================
  // timing
  localparam int UAFE_CLK_HZ        = 50_000_000;
  localparam int UAFE_SUPPLY_WAIT_MS = 64;
  localparam int UAFE_SUPPLY_WAIT_CYC =
    UAFE_CLK_HZ / 1000 * UAFE_SUPPLY_WAIT_MS;

  // ==========================================================================
  // modes, gray along sleep-wait-standby-listen-burst
  typedef enum logic [2:0] {
    UAFE_ST_SLEEP   = 3'b000,
    UAFE_ST_WAIT    = 3'b001,
    UAFE_ST_STANDBY = 3'b011,
    UAFE_ST_LISTEN  = 3'b010,
    UAFE_ST_BURST   = 3'b110
  } uafe_state_type;

  // device state codes as reported
  localparam logic [1:0] UAFE_DEV_LISTEN  = 2'h0;
  localparam logic [1:0] UAFE_DEV_BURST   = 2'h1;
  localparam logic [1:0] UAFE_DEV_STANDBY = 2'h2;
  localparam logic [1:0] UAFE_DEV_SLEEP   = 2'h3;

endpackage : uafe_pkg

// [rtl/uafe_ctrl.sv]
`timescale 1ns/1ps
module uafe_ctrl #(
  parameter int SUPPLY_WAIT_CYC = uafe_pkg::UAFE_SUPPLY_WAIT_CYC
) (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // register port
  input  wire logic [5:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // analog status inputs, asynchronous
  input  wire logic       i_supply_ready,
  input  wire logic       i_env_above_thr,
  input  wire logic       i_zc_comparator,
  // burst sequencer events, same clock
  input  wire logic       i_burst_start,
  input  wire logic       i_burst_end,
  // analog control outputs
  output logic            o_supply_reg_on,
  output logic            o_tx_on,
  output logic            o_rx_on,
  output logic            o_filter_highpass,
  output logic      [5:0] o_filter_freq,
  output logic      [1:0] o_filter_quality,
  output logic      [3:0] o_filter_trim,
  output logic            o_log_first_stage_off,
  output logic            o_log_last_stage_off,
  output logic      [3:0] o_log_intercept_code,
  output logic      [3:0] o_echo_thr_code,
  output logic      [2:0] o_zc_stage_select,
  output logic      [1:0] o_zc_hysteresis,
  output logic      [1:0] o_dev_state,
  // pins
  output logic            o_echo_irq_pin,
  output logic            o_zero_cross_pin,
  output logic            o_irq
);
  import uafe_pkg::*;

  // ==========================================================================
  // configuration registers
  logic [7:0] filter_q, logamp_q, mode_q, drive_q, echo_q, zc_q;
  logic [7:0] irq_stat_q, irq_mask_q;
  logic [7:0] filter2_q;

  // register writes, always accepted in every mode
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      filter_q  <= UAFE_RST_ZERO;
      filter2_q <= UAFE_RST_ZERO;
      logamp_q  <= UAFE_RST_ZERO;
      mode_q    <= UAFE_RST_MODE;
      drive_q   <= UAFE_RST_ZERO;
      echo_q    <= UAFE_RST_ZERO;
      zc_q      <= UAFE_RST_ZERO;
      irq_mask_q <= UAFE_RST_ZERO;
    end else if (i_wr) begin
      if (i_addr == UAFE_ADDR_FILTER) begin
        filter_q <= i_wdata;
      end else if (i_addr == UAFE_ADDR_FILTER2) begin
        filter2_q <= i_wdata;
      end else if (i_addr == UAFE_ADDR_LOGAMP) begin
        logamp_q <= i_wdata;
      end else if (i_addr == UAFE_ADDR_MODE) begin
        mode_q <= i_wdata;
      end else if (i_addr == UAFE_ADDR_DRIVE) begin
        drive_q <= i_wdata;
      end else if (i_addr == UAFE_ADDR_ECHO) begin
        echo_q <= i_wdata;
      end else if (i_addr == UAFE_ADDR_ZC) begin
        zc_q <= i_wdata;
      end else if (i_addr == UAFE_ADDR_IRQ_MASK) begin
        irq_mask_q <= i_wdata;
      end
    end
  end

  // ==========================================================================
  // input synchronisers
  logic [2:0] sync1_q, sync2_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end else begin
      sync1_q <= {i_zc_comparator, i_env_above_thr, i_supply_ready};
      sync2_q <= sync1_q;
    end
  end

  logic supply_ready_s, zc_s;
  assign supply_ready_s = sync2_q[0];
  assign zc_s           = sync2_q[2];

  // ==========================================================================
  // mode machine
  uafe_state_type state_q;
  logic [$clog2(SUPPLY_WAIT_CYC+1)-1:0] wait_q;
  logic sleep_req, stby_req, drv_off, wait_done;

  assign sleep_req = mode_q[UAFE_MODE_SLEEP];
  assign stby_req  = mode_q[UAFE_MODE_STANDBY];
  assign drv_off   = drive_q[UAFE_DRV_DISABLE];
  // ready, timeout, or regulator off
  assign wait_done = supply_ready_s || drv_off
    || (wait_q >= ($bits(wait_q))'(SUPPLY_WAIT_CYC - 1));

  // supply wait counter
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wait_q <= '0;
    end else if (state_q == UAFE_ST_WAIT) begin
      wait_q <= wait_q + 1'b1;
    end else begin
      wait_q <= '0;
    end
  end

  // state transitions
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= UAFE_ST_SLEEP;
    end else if (sleep_req) begin
      state_q <= UAFE_ST_SLEEP;
    end else begin
      case (state_q)
        UAFE_ST_SLEEP: begin
          state_q <= UAFE_ST_WAIT;
        end
        UAFE_ST_WAIT: begin
          if (wait_done) begin
            state_q <= stby_req ? UAFE_ST_STANDBY : UAFE_ST_LISTEN;
          end
        end
        UAFE_ST_STANDBY: begin
          if (!stby_req) begin
            state_q <= UAFE_ST_LISTEN;
          end
        end
        UAFE_ST_LISTEN: begin
          if (stby_req) begin
            state_q <= UAFE_ST_STANDBY;
          end else if (i_burst_start) begin
            state_q <= UAFE_ST_BURST;
          end
        end
        UAFE_ST_BURST: begin
          if (stby_req) begin
            state_q <= UAFE_ST_STANDBY;
          end else if (i_burst_end) begin
            state_q <= UAFE_ST_LISTEN;
          end
        end
        default: begin
          state_q <= UAFE_ST_SLEEP;
        end
      endcase
    end
  end

  // ==========================================================================
  // block enables and reported state
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_supply_reg_on <= 1'b0;
      o_tx_on         <= 1'b0;
      o_rx_on         <= 1'b0;
      o_dev_state     <= UAFE_DEV_SLEEP;
    end else begin
      o_supply_reg_on <= (state_q != UAFE_ST_SLEEP) && !drv_off;
      o_tx_on <= (state_q == UAFE_ST_BURST);
      o_rx_on <= (state_q == UAFE_ST_LISTEN)
              || (state_q == UAFE_ST_BURST);
      case (state_q)
        UAFE_ST_BURST:   o_dev_state <= UAFE_DEV_BURST;
        UAFE_ST_LISTEN:  o_dev_state <= UAFE_DEV_LISTEN;
        UAFE_ST_STANDBY: o_dev_state <= UAFE_DEV_STANDBY;
        default:         o_dev_state <= UAFE_DEV_SLEEP;
      endcase
    end
  end

  // ==========================================================================
  // analog configuration fields
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_filter_highpass     <= 1'b0;
      o_filter_freq         <= 6'h00;
      o_filter_quality      <= 2'h0;
      o_filter_trim         <= 4'h0;
      o_log_first_stage_off <= 1'b0;
      o_log_last_stage_off  <= 1'b0;
      o_log_intercept_code  <= 4'h0;
      o_echo_thr_code       <= 4'h0;
      o_zc_stage_select     <= 3'h0;
      o_zc_hysteresis       <= 2'h0;
    end else begin
      o_filter_highpass <= filter_q[UAFE_FLT_HPF_BIT];
      o_filter_freq     <= filter_q[5:0];
      // quality and trim forced neutral in highpass mode
      o_filter_quality  <= filter_q[UAFE_FLT_HPF_BIT] ? 2'h0
                                                      : filter2_q[5:4];
      o_filter_trim     <= filter_q[UAFE_FLT_HPF_BIT] ? 4'h0
                                                      : filter2_q[3:0];
      o_log_first_stage_off <= logamp_q[UAFE_LOG_FIRST_BIT];
      o_log_last_stage_off  <= logamp_q[UAFE_LOG_LAST_BIT];
      o_log_intercept_code  <= logamp_q[3:0];
      // range bit joins select into the threshold code
      o_echo_thr_code <= {echo_q[UAFE_ECHO_RANGE], echo_q[2:0]};
      o_zc_stage_select <= zc_q[5:3];
      o_zc_hysteresis   <= zc_q[1:0];
    end
  end

  // ==========================================================================
  // echo irq pin: registered rise, asynchronous fall
  // comparator low clears the flop at once; rise waits for synced level
  logic echo_rst;
  assign echo_rst = i_reset || !i_env_above_thr;

  always_ff @(posedge i_clk or posedge echo_rst) begin
    if (echo_rst) begin
      o_echo_irq_pin <= 1'b0;
    end else begin
      o_echo_irq_pin <= sync2_q[1];
    end
  end

  // ==========================================================================
  // zero cross pin
  logic zc_en, zc_gate;
  assign zc_en   = zc_q[UAFE_ZC_EN_BIT];
  assign zc_gate = zc_q[UAFE_ZC_GATE_BIT];

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_zero_cross_pin <= 1'b0;
    end else if (!zc_en) begin
      o_zero_cross_pin <= 1'b0;
    end else if (zc_gate && !o_echo_irq_pin) begin
      o_zero_cross_pin <= 1'b0;
    end else begin
      o_zero_cross_pin <= zc_s;
    end
  end

  // ==========================================================================
  // interrupt status: echo rise, burst end, supply ready
  logic echo_prev_q, ready_prev_q;
  logic [7:0] ev;
  logic rd_stat;
  assign rd_stat = i_rd && (i_addr == UAFE_ADDR_IRQ_STAT);
  assign ev = {5'h00, supply_ready_s && !ready_prev_q,
               i_burst_end && (state_q == UAFE_ST_BURST),
               o_echo_irq_pin && !echo_prev_q};

  // sticky bits, set wins over read clear
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      irq_stat_q   <= 8'h00;
      echo_prev_q  <= 1'b0;
      ready_prev_q <= 1'b0;
    end else begin
      echo_prev_q  <= o_echo_irq_pin;
      ready_prev_q <= supply_ready_s;
      irq_stat_q   <= (rd_stat ? 8'h00 : irq_stat_q) | ev;
    end
  end

  // interrupt output
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(((rd_stat ? 8'h00 : irq_stat_q) | ev) & irq_mask_q);
    end
  end

  // ==========================================================================
  // read data, one cycle after strobe
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (i_addr == UAFE_ADDR_FILTER) begin
        o_rdata <= filter_q;
      end else if (i_addr == UAFE_ADDR_FILTER2) begin
        o_rdata <= filter2_q;
      end else if (i_addr == UAFE_ADDR_LOGAMP) begin
        o_rdata <= logamp_q;
      end else if (i_addr == UAFE_ADDR_MODE) begin
        o_rdata <= mode_q;
      end else if (i_addr == UAFE_ADDR_DRIVE) begin
        o_rdata <= drive_q;
      end else if (i_addr == UAFE_ADDR_ECHO) begin
        o_rdata <= echo_q;
      end else if (i_addr == UAFE_ADDR_ZC) begin
        o_rdata <= zc_q;
      end else if (i_addr == UAFE_ADDR_STATUS) begin
        o_rdata <= {2'h0, supply_ready_s, 3'h0, o_dev_state};
      end else if (i_addr == UAFE_ADDR_IRQ_STAT) begin
        o_rdata <= irq_stat_q;
      end else if (i_addr == UAFE_ADDR_IRQ_MASK) begin
        o_rdata <= irq_mask_q;
      end else begin
        o_rdata <= 8'h00;
      end
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ==========================================================================
  // checks
  sleep_wins_a: assert property (@(posedge i_clk) disable iff (i_reset)
    sleep_req |=> state_q == UAFE_ST_SLEEP)
    else $error("sleep request not honoured");
  sleep_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == UAFE_ST_SLEEP |=> !o_supply_reg_on && !o_tx_on && !o_rx_on)
    else $error("blocks active in sleep");
  drv_skip_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_q == UAFE_ST_WAIT && drv_off && !sleep_req)
      |=> state_q != UAFE_ST_WAIT)
    else $error("supply wait not skipped");
  wait_bound_a: assert property (@(posedge i_clk) disable iff (i_reset)
    wait_q <= ($bits(wait_q))'(SUPPLY_WAIT_CYC))
    else $error("supply wait overran");
  stby_rx_a: assert property (@(posedge i_clk) disable iff (i_reset)
    state_q == UAFE_ST_STANDBY |=> !o_rx_on && !o_tx_on)
    else $error("analog on in standby");
  burst_go_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_q == UAFE_ST_LISTEN && i_burst_start && !stby_req && !sleep_req)
      |=> state_q == UAFE_ST_BURST ##1 o_tx_on && o_rx_on)
    else $error("burst not entered");
  zc_off_a: assert property (@(posedge i_clk) disable iff (i_reset)
    !zc_en |=> !o_zero_cross_pin)
    else $error("zero cross active while off");
  zc_gate_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (zc_en && zc_gate && !o_echo_irq_pin) |=> !o_zero_cross_pin)
    else $error("zero cross not gated");
  echo_rise_a: assert property (@(posedge i_clk) disable iff (i_reset)
    (sync2_q[1] && i_env_above_thr) ##1 i_env_above_thr |-> o_echo_irq_pin)
    else $error("echo irq missing");
  hpf_mask_a: assert property (@(posedge i_clk) disable iff (i_reset)
    filter_q[UAFE_FLT_HPF_BIT] |=> o_filter_trim == 4'h0)
    else $error("trim passed in highpass");
  burst_c: cover property (@(posedge i_clk) disable iff (i_reset)
    state_q == UAFE_ST_BURST ##1 state_q == UAFE_ST_LISTEN);
  wake_c: cover property (@(posedge i_clk) disable iff (i_reset)
    state_q == UAFE_ST_WAIT ##1 state_q == UAFE_ST_STANDBY);
  zc_c: cover property (@(posedge i_clk) disable iff (i_reset)
    o_zero_cross_pin && o_echo_irq_pin);

endmodule : uafe_ctrl

// [bench/uafe_supply_model.sv]
`timescale 1ns/1ps
module uafe_supply_model #(
  parameter int RISE_CYC = 5
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset,
  // regulator control and slow-ramp knob
  input  wire logic i_reg_on,
  input  wire logic i_slow,
  // supply status
  output logic      o_ready
);
  // ==========================================================================
  // supply ramp: collapses when regulator is off, never settles when slow
  int ramp_q;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ramp_q  <= 0;
      o_ready <= 1'b0;
    end else if (!i_reg_on || i_slow) begin
      ramp_q  <= 0;
      o_ready <= 1'b0;
    end else begin
      if (ramp_q < RISE_CYC) ramp_q <= ramp_q + 1;
      o_ready <= (ramp_q >= RISE_CYC);
    end
  end
endmodule : uafe_supply_model

// [bench/tb_uafe_ctrl.sv]
`timescale 1ns/1ps
module tb_uafe_ctrl;
  import uafe_pkg::*;
  // ==========================================================================
  // stimulus, observed outputs and model state
  localparam int WAIT_CYC = 50;
  logic       i_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic [5:0] i_addr = 6'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_env_above_thr = 1'b0, i_zc_comparator = 1'b1;
  logic       i_burst_start = 1'b0, i_burst_end = 1'b0, slow = 1'b0;
  logic       supply_ready, o_supply_reg_on, o_tx_on, o_rx_on, o_irq;
  logic       o_filter_highpass, o_log_first_stage_off, o_log_last_stage_off;
  logic       o_echo_irq_pin, o_zero_cross_pin;
  logic [7:0] o_rdata, rd_v;
  logic [5:0] o_filter_freq;
  logic [3:0] o_filter_trim, o_log_intercept_code, o_echo_thr_code;
  logic [2:0] o_zc_stage_select;
  logic [1:0] o_filter_quality, o_zc_hysteresis, o_dev_state;
  int         errors = 0;
  int         tests_run = 0;
  int         regs [64];

  // 50 MHz clock
  always #10 i_clk = ~i_clk;

  uafe_ctrl #(.SUPPLY_WAIT_CYC(WAIT_CYC)) dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_supply_ready(supply_ready), .i_env_above_thr(i_env_above_thr),
    .i_zc_comparator(i_zc_comparator), .i_burst_start(i_burst_start),
    .i_burst_end(i_burst_end), .o_supply_reg_on(o_supply_reg_on),
    .o_tx_on(o_tx_on), .o_rx_on(o_rx_on),
    .o_filter_highpass(o_filter_highpass), .o_filter_freq(o_filter_freq),
    .o_filter_quality(o_filter_quality), .o_filter_trim(o_filter_trim),
    .o_log_first_stage_off(o_log_first_stage_off),
    .o_log_last_stage_off(o_log_last_stage_off),
    .o_log_intercept_code(o_log_intercept_code),
    .o_echo_thr_code(o_echo_thr_code), .o_zc_stage_select(o_zc_stage_select),
    .o_zc_hysteresis(o_zc_hysteresis), .o_dev_state(o_dev_state),
    .o_echo_irq_pin(o_echo_irq_pin), .o_zero_cross_pin(o_zero_cross_pin),
    .o_irq(o_irq)
  );

  uafe_supply_model #(.RISE_CYC(5)) supply_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_reg_on(o_supply_reg_on),
    .i_slow(slow), .o_ready(supply_ready)
  );

  // ==========================================================================
  // reporting
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t %s seen %0h exp %0h", $time, msg, seen, exp);
    end
  endtask : chk

  // ==========================================================================
  // register port cycles and waits
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr    <= 1'b0;
    regs[a] = d;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask : rd

  task automatic rdc(input logic [5:0] a, input logic [7:0] m);
    logic [7:0] d;
    rd(a, d);
    chk(d & m, 8'(regs[a]) & m, "readback");
  endtask : rdc

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc

  task automatic pulse(input bit is_end);
    @(posedge i_clk);
    if (is_end) i_burst_end <= 1'b1;
    else i_burst_start <= 1'b1;
    @(posedge i_clk);
    i_burst_start <= 1'b0;
    i_burst_end   <= 1'b0;
  endtask : pulse

  task automatic wait_st(input logic [1:0] st, input int n);
    int k;
    k = 0;
    while (o_dev_state !== st && k < n) begin
      cyc(1);
      k++;
    end
    if (o_dev_state !== st) begin
      errors++;
      $display("MISMATCH t=%0t mode wait ran out", $time);
      report_and_stop();
    end
  endtask : wait_st

  // compare every configuration output with the register model
  task automatic chk_cfg();
    logic hp;
    hp = regs[16][6];
    chk(o_filter_highpass, hp, "hp");
    chk(o_filter_freq, regs[16][5:0], "freq");
    chk(o_filter_quality, hp ? 0 : regs[17][5:4], "q");
    chk(o_filter_trim, hp ? 0 : regs[17][3:0], "trim");
    chk(o_log_first_stage_off, regs[18][7], "first");
    chk(o_log_last_stage_off, regs[18][6], "last");
    chk(o_log_intercept_code, regs[18][3:0], "icpt");
    chk(o_echo_thr_code, regs[23][3:0], "thr");
    chk(o_zc_stage_select, regs[24][5:3], "stage");
    chk(o_zc_hysteresis, regs[24][1:0], "hyst");
  endtask : chk_cfg

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(94));
    foreach (regs[i]) regs[i] = 0;
    regs[20] = UAFE_RST_MODE;
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    cyc(2);
    chk(o_dev_state, UAFE_DEV_SLEEP, "rst mode");
    chk(o_supply_reg_on | o_rx_on | o_tx_on, 0, "sleep on");
    chk(o_zero_cross_pin, 0, "zc off");
    rdc(UAFE_ADDR_MODE, 8'h03);
    // every intercept code with random fields, all written in sleep
    for (int i = 0; i < 16; i++) begin
      wr(UAFE_ADDR_FILTER, 8'($urandom & 32'h7F));
      wr(UAFE_ADDR_FILTER2, 8'($urandom & 32'h3F));
      wr(UAFE_ADDR_LOGAMP, 8'(($urandom & 32'hC0) | i));
      wr(UAFE_ADDR_ECHO, 8'($urandom & 32'h0F));
      wr(UAFE_ADDR_ZC, 8'($urandom & 32'h3B));
      cyc(2);
      chk_cfg();
      rdc(UAFE_ADDR_FILTER, 8'h7F);
      rdc(UAFE_ADDR_LOGAMP, 8'hFF);
    end
    wr(6'h3F, 8'hA5);
    rd(6'h3F, rd_v);
    chk(rd_v, 0, "unmapped");
    $display("test config done");
    // regulator disabled: leave sleep with no supply wait
    wr(UAFE_ADDR_DRIVE, 8'h80);
    wr(UAFE_ADDR_MODE, 8'h00);
    wait_st(UAFE_DEV_LISTEN, 4);
    cyc(1);
    chk({o_tx_on, o_rx_on}, 2'b01, "listen en");
    rd(UAFE_ADDR_STATUS, rd_v);
    chk(rd_v[1:0], UAFE_DEV_LISTEN, "status");
    // supply never settles: fallback count ends the wait
    wr(UAFE_ADDR_MODE, 8'h02);
    wait_st(UAFE_DEV_SLEEP, 4);
    wr(UAFE_ADDR_DRIVE, 8'h00);
    slow = 1'b1;
    wr(UAFE_ADDR_MODE, 8'h00);
    cyc(WAIT_CYC - 10);
    chk(o_rx_on, 0, "early exit");
    wait_st(UAFE_DEV_LISTEN, 30);
    // prompt supply: standby long before the fallback count
    wr(UAFE_ADDR_MODE, 8'h02);
    wait_st(UAFE_DEV_SLEEP, 4);
    slow = 1'b0;
    wr(UAFE_ADDR_MODE, 8'h01);
    wait_st(UAFE_DEV_STANDBY, 20);
    cyc(1);
    chk({o_supply_reg_on, o_rx_on, o_tx_on}, 3'b100, "standby");
    wr(UAFE_ADDR_MODE, 8'h03);
    wait_st(UAFE_DEV_SLEEP, 4);
    cyc(1);
    chk(o_supply_reg_on, 0, "sleep reg");
    $display("test modes done");
    // burst round trip with end-of-burst interrupt
    wr(UAFE_ADDR_DRIVE, 8'h80);
    wr(UAFE_ADDR_MODE, 8'h00);
    wait_st(UAFE_DEV_LISTEN, 4);
    wr(UAFE_ADDR_IRQ_MASK, 8'h02);
    rd(UAFE_ADDR_IRQ_STAT, rd_v);
    pulse(1'b0);
    wait_st(UAFE_DEV_BURST, 3);
    cyc(1);
    chk({o_tx_on, o_rx_on}, 2'b11, "burst en");
    pulse(1'b1);
    wait_st(UAFE_DEV_LISTEN, 3);
    cyc(2);
    chk(o_irq, 1, "irq set");
    wr(UAFE_ADDR_IRQ_MASK, 8'h00);
    cyc(2);
    chk(o_irq, 0, "irq masked");
    wr(UAFE_ADDR_IRQ_MASK, 8'h02);
    cyc(2);
    chk(o_irq, 1, "irq unmasked");
    rd(UAFE_ADDR_IRQ_STAT, rd_v);
    chk(rd_v[1], 1, "irq stat");
    cyc(2);
    chk(o_irq, 0, "irq cleared");
    $display("test burst done");
    // echo pin rises on the envelope, falls at once
    @(posedge i_clk) i_env_above_thr <= 1'b1;
    cyc(3);
    chk(o_echo_irq_pin, 1, "echo rise");
    cyc(3);
    chk(o_echo_irq_pin, 1, "echo hold");
    @(posedge i_clk) i_env_above_thr <= 1'b0;
    #1 chk(o_echo_irq_pin, 0, "echo fall");
    // zero cross follows comparator, then only inside echo
    wr(UAFE_ADDR_ZC, 8'($urandom & 32'h3B) | 8'h80);
    @(posedge i_clk) i_zc_comparator <= 1'b0;
    cyc(5);
    chk(o_zero_cross_pin, 0, "zc low");
    chk_cfg();
    @(posedge i_clk) i_zc_comparator <= 1'b1;
    cyc(5);
    chk(o_zero_cross_pin, 1, "zc high");
    wr(UAFE_ADDR_ZC, 8'hC0);
    cyc(5);
    chk(o_zero_cross_pin, 0, "zc gated");
    @(posedge i_clk) i_env_above_thr <= 1'b1;
    cyc(5);
    chk(o_zero_cross_pin, 1, "zc open");
    @(posedge i_clk) i_env_above_thr <= 1'b0;
    wr(UAFE_ADDR_LOGAMP, 8'h00);
    cyc(2);
    chk_cfg();
    $display("test pins done");
    report_and_stop();
  end
endmodule : tb_uafe_ctrl
